// ### cgwf_gateway.sv
`timescale 1ns/100ps
module cgwf_gateway import cgwf_pkg::*; #(
  parameter logic [TGT_W-1:0] FIFO_INDEX = 4'h0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic rx_valid_i,
  input wire logic [TGT_W-1:0] filter_rule_target_pointer_i,
  input wire logic [FRAME_W-1:0] rx_frame_i,
  output logic tx_req_o,
  output logic [FRAME_W-1:0] tx_frame_o,
  input wire logic tx_start_i,
  input wire logic tx_done_i,
  input wire logic tx_err_i,
  input wire logic tx_arb_lost_i,
  input wire logic bit_tick_i,
  input wire logic chan_reset_i,
  output logic mirror_valid_o,
  output logic [FRAME_W-1:0] mirror_frame_o,
  output logic rx_irq_o,
  output logic tx_irq_o
);
  logic fifo_enable_bit, next_fifo_enable_bit;
  cgwf_mode_type fifo_operating_mode, next_fifo_operating_mode;
  logic fifo_rx_irq_enable, next_fifo_rx_irq_enable;
  logic fifo_tx_irq_enable, next_fifo_tx_irq_enable;
  logic fifo_interrupt_mode, next_fifo_interrupt_mode;
  logic [2:0] fill_threshold_code, next_fill_threshold_code;
  logic [2:0] fifo_depth_code, next_fifo_depth_code;
  logic interval_range_select, next_interval_range_select;
  logic interval_source_select, next_interval_source_select;
  logic full_capture, next_full_capture;
  logic [7:0] interval_count_value, next_interval_count_value;
  logic [15:0] interval_prescaler_value, next_interval_prescaler_value;
  logic lost_flag, next_lost_flag;
  logic rx_flag, next_rx_flag;
  logic fifo_tx_irq_flag, next_fifo_tx_irq_flag;
  logic abort_pending, next_abort_pending;
  cgwf_tx_state_type state, next_state;
  logic [7:0] gap_cnt, next_gap_cnt;
  logic next_tx_req;
  logic [FRAME_W-1:0] next_tx_frame;
  logic next_mirror_valid;
  logic [FRAME_W-1:0] next_mirror_frame;
  logic [DATA_W-1:0] next_rdata;

  logic [FRAME_W-1:0] head;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] depth;
  logic [CNT_W-1:0] thr_level;
  logic [CNT_W+3:0] thr_mult;
  logic presc_tick, tick;
  logic full, hit, hw_push, sw_push, push, over, pop, sw_pop, tx_pop;
  logic flush, auto_tx, cfg_wr, st_wr, rx_event, tx_event;
  logic [DATA_W-1:0] cfg_word, st_word;

  cgwf_store u_store (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(flush),
    .push_i(push),
    .over_i(over),
    .pop_i(pop),
    .data_i(sw_push ? wdata_i : rx_frame_i),
    .head_o(head),
    .count_o(count)
  );

  // prescaler runs only while waiting, so every wait starts phase aligned
  cgwf_tick u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(state == TX_GAP),
    .div_i(interval_prescaler_value),
    .range_i(interval_range_select),
    .tick_o(presc_tick)
  );

  always_comb begin
    cfg_wr = wr_i && addr_i == ADDR_CONFIG;
    st_wr = wr_i && addr_i == ADDR_STATUS;
    depth = cgwf_depth(fifo_depth_code);
    full = count >= depth;
    auto_tx = fifo_operating_mode == MODE_TX || fifo_operating_mode == MODE_GW;
    flush = !fifo_enable_bit;
    hit = rx_valid_i && filter_rule_target_pointer_i == FIFO_INDEX && fifo_enable_bit
      && fifo_operating_mode != MODE_TX;
    // frame contents reachable by software outside gateway only
    sw_push = wr_i && addr_i == ADDR_ACCESS && fifo_operating_mode == MODE_TX && fifo_enable_bit && !full;
    sw_pop = rd_i && addr_i == ADDR_ACCESS && fifo_operating_mode == MODE_RX && count != '0;
    // storing goes on during the interval wait
    hw_push = hit && !full;
    // when full, overwrite newest or drop
    over = hit && full && full_capture;
    push = hw_push || sw_push;
    tx_pop = state == TX_SEND && tx_done_i && fifo_enable_bit;
    pop = tx_pop || sw_pop;
    tick = interval_source_select ? bit_tick_i : presc_tick;
    // fill level in eighths of depth, at least one frame
    thr_mult = {4'h0, depth} * ({6'h00, fill_threshold_code} + 9'h001);
    thr_level = thr_mult[CNT_W+2:EIGHTHS_SHIFT];
    if (thr_level == '0) begin
      thr_level = 5'h01;
    end
    // per frame, else on reaching the threshold
    rx_event = fifo_interrupt_mode ? (hw_push || over) : (hw_push && count + 5'h01 == thr_level);
    // per frame or on drain; abort adds no source
    tx_event = fifo_interrupt_mode ? (state == TX_SEND && tx_done_i) : (tx_pop && count == 5'h01);
  end

  always_comb begin
    next_fifo_enable_bit = fifo_enable_bit;
    next_fifo_operating_mode = fifo_operating_mode;
    next_fifo_rx_irq_enable = fifo_rx_irq_enable;
    next_fifo_tx_irq_enable = fifo_tx_irq_enable;
    next_fifo_interrupt_mode = fifo_interrupt_mode;
    next_fill_threshold_code = fill_threshold_code;
    next_fifo_depth_code = fifo_depth_code;
    next_interval_range_select = interval_range_select;
    next_interval_source_select = interval_source_select;
    next_full_capture = full_capture;
    next_interval_count_value = interval_count_value;
    next_interval_prescaler_value = interval_prescaler_value;
    if (cfg_wr) begin
      next_fifo_enable_bit = wdata_i[CFG_EN];
      next_fifo_operating_mode = cgwf_mode_type'(wdata_i[CFG_MODE_LO +: 2]);
      next_fifo_rx_irq_enable = wdata_i[CFG_RXIE];
      next_fifo_tx_irq_enable = wdata_i[CFG_TXIE];
      next_fifo_interrupt_mode = wdata_i[CFG_IM];
      next_fill_threshold_code = wdata_i[CFG_THR_LO +: 3];
      next_fifo_depth_code = wdata_i[CFG_DEPTH_LO +: 3];
      next_interval_range_select = wdata_i[CFG_RANGE];
      next_interval_source_select = wdata_i[CFG_SRC];
      next_full_capture = wdata_i[CFG_CAPTURE];
      next_interval_count_value = wdata_i[CFG_INTV_LO +: 8];
    end
    if (wr_i && addr_i == ADDR_GLOBAL) begin
      next_interval_prescaler_value = wdata_i[15:0];
    end
  end

  // flags: writing zero clears, a same-cycle event wins
  always_comb begin
    next_lost_flag = lost_flag;
    next_rx_flag = rx_flag;
    next_fifo_tx_irq_flag = fifo_tx_irq_flag;
    if (st_wr && !wdata_i[ST_LOST]) begin
      next_lost_flag = 1'b0;
    end
    if (st_wr && !wdata_i[ST_RXIRQ]) begin
      next_rx_flag = 1'b0;
    end
    if (st_wr && !wdata_i[ST_TXIRQ]) begin
      next_fifo_tx_irq_flag = 1'b0;
    end
    if (hit && full && !full_capture) begin
      next_lost_flag = 1'b1;
    end
    if (rx_event) begin
      next_rx_flag = 1'b1;
    end
    if (tx_event) begin
      next_fifo_tx_irq_flag = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_gap_cnt = gap_cnt;
    next_tx_req = tx_req_o;
    next_tx_frame = tx_frame_o;
    next_mirror_valid = 1'b0;
    next_mirror_frame = mirror_frame_o;
    next_abort_pending = abort_pending;
    // abort waits only for a frame offered or on the bus
    if (cfg_wr && !wdata_i[CFG_EN] && (state == TX_REQ || state == TX_SEND)) begin
      next_abort_pending = 1'b1;
    end
    case (state)
      TX_IDLE: begin
        if (fifo_enable_bit && auto_tx && count != '0 && !chan_reset_i) begin
          next_state = TX_REQ;
          next_tx_req = 1'b1;
          next_tx_frame = head;
        end
      end
      TX_REQ: begin
        // request held until channel starts it or, with an abort pending, reports error or lost arbitration
        if (tx_start_i) begin
          next_state = TX_SEND;
        end else if ((tx_err_i || tx_arb_lost_i) && abort_pending) begin
          next_state = TX_IDLE;
          next_tx_req = 1'b0;
          next_abort_pending = 1'b0;
        end
      end
      TX_SEND: begin
        if (tx_done_i) begin
          next_tx_req = 1'b0;
          // sent frames stay visible through the mirror path
          next_mirror_valid = 1'b1;
          next_mirror_frame = tx_frame_o;
          next_gap_cnt = 8'h00;
          if (abort_pending) begin
            next_state = TX_IDLE;
            next_abort_pending = 1'b0;
          end else if (interval_count_value != 8'h00) begin
            next_state = TX_GAP;
          end else begin
            next_state = TX_IDLE;
          end
        end else if (tx_err_i || tx_arb_lost_i) begin
          // abort ends on error or lost arbitration, else retry
          if (abort_pending) begin
            next_state = TX_IDLE;
            next_tx_req = 1'b0;
            next_abort_pending = 1'b0;
          end else begin
            next_state = TX_REQ;
          end
        end
      end
      TX_GAP: begin
        // timer stops on disable or channel reset
        if (!fifo_enable_bit || chan_reset_i) begin
          next_state = TX_IDLE;
          next_gap_cnt = 8'h00;
        // expiry releases next frame, timer cleared
        end else if (tick) begin
          if (gap_cnt + 8'h01 >= interval_count_value) begin
            next_state = TX_IDLE;
            next_gap_cnt = 8'h00;
          end else begin
            next_gap_cnt = gap_cnt + 8'h01;
          end
        end
      end
      default: begin
        next_state = TX_IDLE;
        next_tx_req = 1'b0;
      end
    endcase
  end

  always_comb begin
    cfg_word = '0;
    cfg_word[CFG_EN] = fifo_enable_bit;
    cfg_word[CFG_MODE_LO +: 2] = fifo_operating_mode;
    cfg_word[CFG_RXIE] = fifo_rx_irq_enable;
    cfg_word[CFG_TXIE] = fifo_tx_irq_enable;
    cfg_word[CFG_IM] = fifo_interrupt_mode;
    cfg_word[CFG_THR_LO +: 3] = fill_threshold_code;
    cfg_word[CFG_DEPTH_LO +: 3] = fifo_depth_code;
    cfg_word[CFG_RANGE] = interval_range_select;
    cfg_word[CFG_SRC] = interval_source_select;
    cfg_word[CFG_CAPTURE] = full_capture;
    cfg_word[CFG_INTV_LO +: 8] = interval_count_value;
    st_word = '0;
    // empty only once any aborted frame has finished
    st_word[ST_EMPTY] = count == '0 && !abort_pending;
    st_word[ST_FULL] = full;
    st_word[ST_LOST] = lost_flag;
    st_word[ST_RXIRQ] = rx_flag;
    st_word[ST_TXIRQ] = fifo_tx_irq_flag;
    st_word[ST_CNT_LO +: CNT_W] = count;
    next_rdata = '0;
    if (rd_i) begin
      case (addr_i)
        ADDR_CONFIG: next_rdata = cfg_word;
        ADDR_STATUS: next_rdata = st_word;
        ADDR_GLOBAL: next_rdata = {16'h0000, interval_prescaler_value};
        ADDR_ACCESS: next_rdata = sw_pop ? head : '0;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fifo_enable_bit <= 1'b0;
      fifo_operating_mode <= MODE_RX;
      fifo_rx_irq_enable <= 1'b0;
      fifo_tx_irq_enable <= 1'b0;
      fifo_interrupt_mode <= 1'b0;
      fill_threshold_code <= 3'h0;
      fifo_depth_code <= DEPTH_RESET;
      interval_range_select <= 1'b0;
      interval_source_select <= 1'b0;
      full_capture <= 1'b0;
      interval_count_value <= INTERVAL_RESET;
      interval_prescaler_value <= PRESCALE_RESET;
      lost_flag <= 1'b0;
      rx_flag <= 1'b0;
      fifo_tx_irq_flag <= 1'b0;
      abort_pending <= 1'b0;
      state <= TX_IDLE;
      gap_cnt <= 8'h00;
      tx_req_o <= 1'b0;
      tx_frame_o <= '0;
      mirror_valid_o <= 1'b0;
      mirror_frame_o <= '0;
      rdata_o <= '0;
      rx_irq_o <= 1'b0;
      tx_irq_o <= 1'b0;
    end else begin
      fifo_enable_bit <= next_fifo_enable_bit;
      fifo_operating_mode <= next_fifo_operating_mode;
      fifo_rx_irq_enable <= next_fifo_rx_irq_enable;
      fifo_tx_irq_enable <= next_fifo_tx_irq_enable;
      fifo_interrupt_mode <= next_fifo_interrupt_mode;
      fill_threshold_code <= next_fill_threshold_code;
      fifo_depth_code <= next_fifo_depth_code;
      interval_range_select <= next_interval_range_select;
      interval_source_select <= next_interval_source_select;
      full_capture <= next_full_capture;
      interval_count_value <= next_interval_count_value;
      interval_prescaler_value <= next_interval_prescaler_value;
      lost_flag <= next_lost_flag;
      rx_flag <= next_rx_flag;
      fifo_tx_irq_flag <= next_fifo_tx_irq_flag;
      abort_pending <= next_abort_pending;
      state <= next_state;
      gap_cnt <= next_gap_cnt;
      tx_req_o <= next_tx_req;
      tx_frame_o <= next_tx_frame;
      mirror_valid_o <= next_mirror_valid;
      mirror_frame_o <= next_mirror_frame;
      rdata_o <= next_rdata;
      // outputs gated by enables, flags survive disable
      rx_irq_o <= next_rx_flag && next_fifo_rx_irq_enable;
      tx_irq_o <= next_fifo_tx_irq_flag && next_fifo_tx_irq_enable;
    end
  end
endmodule // cgwf_gateway

// ### cgwf_pkg.sv
package cgwf_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int FRAME_W = 32;
  localparam int STORE_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int TGT_W = 4;

  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ACCESS = 8'h0c;

  localparam int CFG_EN = 0;
  localparam int CFG_MODE_LO = 1;
  localparam int CFG_RXIE = 3;
  localparam int CFG_TXIE = 4;
  localparam int CFG_IM = 5;
  localparam int CFG_THR_LO = 6;
  localparam int CFG_DEPTH_LO = 9;
  localparam int CFG_RANGE = 12;
  localparam int CFG_SRC = 13;
  localparam int CFG_CAPTURE = 14;
  localparam int CFG_INTV_LO = 16;

  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_LOST = 2;
  localparam int ST_RXIRQ = 3;
  localparam int ST_TXIRQ = 4;
  localparam int ST_CNT_LO = 8;

  localparam logic [15:0] PRESCALE_RESET = 16'h0001;
  localparam logic [7:0] INTERVAL_RESET = 8'h00;
  localparam logic [2:0] DEPTH_RESET = 3'h1;
  localparam logic [2:0] DEPTH_CODE_4 = 3'h1;
  localparam logic [2:0] DEPTH_CODE_8 = 3'h2;
  localparam logic [CNT_W-1:0] DEPTH_4 = 5'h04;
  localparam logic [CNT_W-1:0] DEPTH_8 = 5'h08;
  localparam logic [CNT_W-1:0] DEPTH_16 = 5'h10;
  localparam logic [3:0] RANGE_DIV_LAST = 4'h9;
  localparam int EIGHTHS_SHIFT = 3;

  typedef enum logic [1:0] {
    MODE_RX = 2'b00,
    MODE_TX = 2'b01,
    MODE_GW = 2'b10
  } cgwf_mode_type;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_REQ,
    TX_SEND,
    TX_GAP
  } cgwf_tx_state_type;

  function automatic logic [CNT_W-1:0] cgwf_depth(input logic [2:0] code);
    case (code)
      DEPTH_CODE_4: cgwf_depth = DEPTH_4;
      DEPTH_CODE_8: cgwf_depth = DEPTH_8;
      default: cgwf_depth = DEPTH_16;
    endcase
  endfunction
endpackage

// ### cgwf_tick.sv
`timescale 1ns/100ps
module cgwf_tick import cgwf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [15:0] div_i,
  input wire logic range_i,
  output logic tick_o
);
  logic half, next_half;
  logic [15:0] mcnt, next_mcnt;
  logic [3:0] dcnt, next_dcnt;
  logic next_tick;

  always_comb begin
    next_half = 1'b0;
    next_mcnt = 16'h0000;
    next_dcnt = 4'h0;
    next_tick = 1'b0;
    if (run_i) begin
      next_half = ~half;
      next_mcnt = mcnt;
      next_dcnt = dcnt;
      if (half) begin
        // zero divider behaves as one, never a stuck timer
        if (mcnt + 16'h0001 >= div_i || div_i == 16'h0000) begin
          next_mcnt = 16'h0000;
          if (!range_i) begin
            next_tick = 1'b1;
          end else if (dcnt == RANGE_DIV_LAST) begin
            next_dcnt = 4'h0;
            next_tick = 1'b1;
          end else begin
            next_dcnt = dcnt + 4'h1;
          end
        end else begin
          next_mcnt = mcnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half <= 1'b0;
      mcnt <= 16'h0000;
      dcnt <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      half <= next_half;
      mcnt <= next_mcnt;
      dcnt <= next_dcnt;
      tick_o <= next_tick;
    end
  end
endmodule // cgwf_tick

// ### cgwf_store.sv
`timescale 1ns/100ps
module cgwf_store import cgwf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic over_i,
  input wire logic pop_i,
  input wire logic [FRAME_W-1:0] data_i,
  output logic [FRAME_W-1:0] head_o,
  output logic [CNT_W-1:0] count_o
);
  logic [FRAME_W-1:0] mem [STORE_DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CNT_W-1:0] count, next_count;

  assign head_o = mem[rd_ptr];
  assign count_o = count;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else begin
      if (push_i) begin
        next_wr_ptr = wr_ptr + 4'h1;
      end
      if (pop_i) begin
        next_rd_ptr = rd_ptr + 4'h1;
      end
      next_count = count + {4'h0, push_i} - {4'h0, pop_i};
    end
  end

  // data array carries no reset, pointers alone define content
  always_ff @(posedge clk_i) begin
    if (!flush_i && push_i) begin
      mem[wr_ptr] <= data_i;
    end else if (!flush_i && over_i) begin
      mem[wr_ptr - 4'h1] <= data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule // cgwf_store

// ### cgwf_asserts.sv
`timescale 1ns/100ps
module cgwf_asserts import cgwf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rx_valid_i,
  input wire logic tx_req_o,
  input wire logic [FRAME_W-1:0] tx_frame_o,
  input wire logic tx_done_i,
  input wire logic tx_err_i,
  input wire logic tx_arb_lost_i,
  input wire logic chan_reset_i,
  input wire logic mirror_valid_o,
  input wire logic [FRAME_W-1:0] mirror_frame_o,
  input wire logic rx_irq_o,
  input wire logic tx_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_mir_done; mirror_valid_o |-> $past(tx_done_i); endproperty
  a_mir_done: assert property (p_mir_done) else $error("mirror without completion");
  property p_mir_frame; mirror_valid_o |-> mirror_frame_o == $past(tx_frame_o); endproperty
  a_mir_frame: assert property (p_mir_frame) else $error("mirror frame differs");
  property p_frame_hold; tx_req_o && $past(tx_req_o) |-> $stable(tx_frame_o); endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("offered frame changed");
  property p_req_hold; tx_req_o && !tx_done_i && !tx_err_i && !tx_arb_lost_i && !chan_reset_i |=> tx_req_o; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_req_drop; tx_req_o && tx_done_i |=> !tx_req_o; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after done");
  property p_rst_idle; chan_reset_i && !tx_req_o |=> !tx_req_o; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("request in channel reset");
  property p_rx_cause; $rose(rx_irq_o) |-> $past(rx_valid_i) || $past(rx_valid_i, 2) || $past(wr_i) || $past(wr_i, 2); endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("rx irq without cause");
  property p_tx_cause; $rose(tx_irq_o) |-> $past(tx_done_i) || $past(tx_done_i, 2) || $past(wr_i) || $past(wr_i, 2); endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("tx irq without completion");
endmodule // cgwf_asserts

bind cgwf_gateway cgwf_asserts i_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rx_valid_i(rx_valid_i),
  .tx_req_o(tx_req_o), .tx_frame_o(tx_frame_o), .tx_done_i(tx_done_i), .tx_err_i(tx_err_i),
  .tx_arb_lost_i(tx_arb_lost_i), .chan_reset_i(chan_reset_i), .mirror_valid_o(mirror_valid_o),
  .mirror_frame_o(mirror_frame_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));

// ### cgwf_chan_model.sv
`timescale 1ns/100ps
module cgwf_chan_model import cgwf_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tx_req_i,
  input wire logic slow_i,
  input wire logic fault_i,
  output logic bit_tick_o,
  output logic tx_start_o,
  output logic tx_done_o,
  output logic tx_err_o,
  output logic tx_arb_lost_o
);
  logic [1:0] div;
  logic [3:0] cnt;
  logic busy;
  logic used;
  // bit time is four clocks; short, so runs stay brief
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {div, cnt, busy, used} <= '0;
      {bit_tick_o, tx_start_o, tx_done_o, tx_err_o, tx_arb_lost_o} <= '0;
    end else begin
      div <= div + 2'd1;
      bit_tick_o <= (div == 2'd3);
      {tx_start_o, tx_done_o, tx_err_o, tx_arb_lost_o} <= '0;
      if (!fault_i) used <= 1'b0;
      if (!busy && !tx_req_i) cnt <= '0;
      else if (div == 2'd3 && busy) begin
        cnt <= cnt + 4'd1;
        if (cnt == 4'd7) begin
          busy <= 1'b0;
          cnt <= '0;
          tx_done_o <= !(fault_i && slow_i);
          tx_err_o <= fault_i && slow_i;
        end
      end else if (div == 2'd3) begin
        cnt <= cnt + 4'd1;
        if (cnt == (slow_i ? 4'd2 : 4'd0)) begin
          cnt <= '0;
          used <= fault_i;
          tx_arb_lost_o <= fault_i && !used && !slow_i;
          tx_start_o <= !(fault_i && !used && !slow_i);
          busy <= !(fault_i && !used && !slow_i);
        end
      end
    end
  end
endmodule // cgwf_chan_model

// ### testbench.sv
`timescale 1ns/100ps
module testbench import cgwf_pkg::*;;
  localparam logic [TGT_W-1:0] IDX = 4'h3;
  localparam logic [DATA_W-1:0] EN = 32'h1, GW = 32'h4, RXIE = 32'h8, TXIE = 32'h10, IM = 32'h20;
  localparam logic [DATA_W-1:0] D8 = 32'h400, SRC = 32'h2000, CAP = 32'h4000;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rx_valid_i = 0, chan_reset_i = 0, slow = 0, fault = 0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0, rdata_o;
  logic [TGT_W-1:0] tgt = '0;
  logic [FRAME_W-1:0] rx_frame_i = '0, tx_frame_o, mirror_frame_o;
  logic tx_req_o, tx_start_i, tx_done_i, tx_err_i, tx_arb_lost_i, bit_tick_i, mirror_valid_o, rx_irq_o, tx_irq_o;
  logic rd_d = 0;
  logic [FRAME_W-1:0] exp_q[$];
  logic [DATA_W-1:0] rv_q[$], rm_q[$];
  int miscompares = 0, n_checks = 0, gap_c = 0, gap_t = 0, lgap_c = 0, lgap_t = 0;

  cgwf_gateway #(.FIFO_INDEX(IDX)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_valid_i(rx_valid_i), .filter_rule_target_pointer_i(tgt),
    .rx_frame_i(rx_frame_i), .tx_req_o(tx_req_o), .tx_frame_o(tx_frame_o), .tx_start_i(tx_start_i),
    .tx_done_i(tx_done_i), .tx_err_i(tx_err_i), .tx_arb_lost_i(tx_arb_lost_i), .bit_tick_i(bit_tick_i),
    .chan_reset_i(chan_reset_i), .mirror_valid_o(mirror_valid_o), .mirror_frame_o(mirror_frame_o),
    .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
  cgwf_chan_model i_chan (.clk_i(clk_i), .rst_n_i(rst_n_i), .tx_req_i(tx_req_o), .slow_i(slow), .fault_i(fault),
    .bit_tick_o(bit_tick_i), .tx_start_o(tx_start_i), .tx_done_o(tx_done_i), .tx_err_o(tx_err_i),
    .tx_arb_lost_o(tx_arb_lost_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] m);
    rv_q.push_back(e);
    rm_q.push_back(m);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic push(input logic [TGT_W-1:0] t, input bit keep, output logic [FRAME_W-1:0] f);
    f = $urandom;
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    rx_frame_i <= f;
    tgt <= t;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    if (keep) exp_q.push_back(f);
  endtask

  // bounded wait for every noted frame to be mirrored
  task automatic drain();
    int i;
    for (i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clk_i);
    if (exp_q.size() != 0) begin
      miscompares++;
      print_verdict();
    end
  endtask

  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d === 1'b1) begin
      check(rdata_o & rm_q[0], rv_q.pop_front() & rm_q[0]);
      void'(rm_q.pop_front());
    end
    if (mirror_valid_o === 1'b1) check(mirror_frame_o, exp_q.pop_front());
    gap_c <= tx_req_o ? 0 : gap_c + 1;
    gap_t <= tx_req_o ? 0 : gap_t + bit_tick_i;
    if (tx_req_o && gap_c != 0) begin
      lgap_c <= gap_c;
      lgap_t <= gap_t;
    end
  end

  initial begin
    int i, j, k;
    logic [FRAME_W-1:0] f;
    void'($urandom(32'h06175b1e));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ADDR_CONFIG, 32'h200, '1);
    rd(ADDR_GLOBAL, 32'h1, '1);
    rd(8'h10, 32'h0, '1);
    // routed burst in order, first attempt loses arbitration
    fault <= 1'b1;
    wr(ADDR_CONFIG, EN | GW | RXIE | TXIE | IM | D8 | SRC | 32'h3_0000);
    for (i = 0; i < 3; i++) push(IDX, 1, f);
    push(4'h5, 0, f);
    rd(ADDR_ACCESS, 32'h0, '1);
    drain();
    fault <= 1'b0;
    check(lgap_t inside {[2:4]}, 1'b1);
    check({rx_irq_o, tx_irq_o}, 2'b11);
    rd(ADDR_STATUS, 32'h19, 32'h1f1f);
    wr(ADDR_STATUS, 32'h0);
    repeat (3) @(posedge clk_i);
    check({rx_irq_o, tx_irq_o}, 2'b00);
    // prescaled interval, plain and with range
    for (k = 0; k < 2; k++) begin
      wr(ADDR_GLOBAL, 32'(3 - k));
      wr(ADDR_CONFIG, EN | GW | D8 | (k ? 32'h1000 : 32'h0) | 32'(2 - k) << 16);
      for (i = 0; i < 2; i++) push(IDX, 1, f);
      drain();
      j = 2 * (3 - k) * (2 - k) * (k ? 10 : 1);
      check(lgap_c inside {[j:j + 3]}, 1'b1);
    end
    // every threshold code, ignored push while disabled
    for (k = 0; k < 8; k++) begin
      wr(ADDR_CONFIG, 32'h0);
      wr(ADDR_STATUS, 32'h0);
      push(IDX, 0, f);
      wr(ADDR_CONFIG, EN | RXIE | D8 | 32'(k) << 6);
      for (i = 0; i <= k; i++) begin
        push(IDX, 0, f);
        rd(ADDR_STATUS, 32'(i + 1) << 8 | 32'(i == k) << 3 | 32'(i == 7) << 1, 32'h1f0b);
      end
    end
    check(rx_irq_o, 1'b1);
    wr(ADDR_CONFIG, EN | D8);
    repeat (3) @(posedge clk_i);
    check(rx_irq_o, 1'b0);
    // full: drop, then capture over newest
    push(IDX, 0, f);
    rd(ADDR_STATUS, 32'h0806, 32'h1f07);
    wr(ADDR_STATUS, 32'h0);
    wr(ADDR_CONFIG, EN | D8 | CAP);
    push(IDX, 0, f);
    rd(ADDR_STATUS, 32'h0802, 32'h1f07);
    for (i = 0; i < 7; i++) rd(ADDR_ACCESS, 32'h0, 32'h0);
    rd(ADDR_ACCESS, f, '1);
    // channel reset holds frames, disable empties at once
    chan_reset_i <= 1'b1;
    wr(ADDR_CONFIG, 32'h0);
    wr(ADDR_CONFIG, EN | GW | D8);
    push(IDX, 0, f);
    push(IDX, 0, f);
    repeat (20) @(posedge clk_i);
    check(tx_req_o, 1'b0);
    rd(ADDR_STATUS, 32'h0200, 32'h1f01);
    wr(ADDR_CONFIG, 32'h0);
    rd(ADDR_STATUS, 32'h1, 32'h1f01);
    chan_reset_i <= 1'b0;
    // abort with one frame on the bus, slow channel
    slow <= 1'b1;
    wr(ADDR_STATUS, 32'h0);
    wr(ADDR_CONFIG, EN | GW | TXIE | IM | D8 | SRC);
    push(IDX, 1, f);
    push(IDX, 0, f);
    for (i = 0; i < 200 && tx_start_i !== 1'b1; i++) @(posedge clk_i);
    // no start within the bound counts as a hang
    if (tx_start_i !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
    wr(ADDR_CONFIG, TXIE | IM);
    rd(ADDR_STATUS, 32'h0, 32'h1);
    drain();
    repeat (100) @(posedge clk_i);
    rd(ADDR_STATUS, 32'h19, 32'h1f1f);
    repeat (3) @(posedge clk_i);
    print_verdict();
  end
endmodule // testbench
